// ---- hw/spmc_regs.svh ----
// register offsets, fields, reset values and timing counts of the power mode controller
// Function
// - after reset the device runs in normal mode with clocks, PHYs, MACs, management on
// - mode field bits [4:3]: 00 selects normal, 01 selects energy detect
// - only one global power mode is in effect at any time
// - energy detect: no energy beyond timeout moves normal-power to low-power state
// - low-power state disables all but energy detector, sends sparse link pulses
// - energy present over 100ns in low-power state returns to normal-power
// - soft power-down disables everything except the management interface
// - leaving soft power-down resets every register and resamples straps
// - per-port power-down is independent of mode; EEE acts only on ports not powered down, in normal or normal-power state
// - low-power idle exists only on PHY ports 1 and 2, never port 3
// - EEE off after reset, active only when both link ends negotiate it
// - transmit LPI held while the MAC requests it; transmit clock keeps running
// - in transmit LPI a refresh burst of 200-220us is sent every 20-22ms
// - receive refresh pattern enters LPI and tells MAC; other patterns resume frames
// - receive clock may stop after nine or more cycles in receive LPI
// - transmit and receive LPI are controlled separately per link
// - wake event asserts interrupt or power event output, as host programmed
// - wake events: energy beyond programmed time, link-up, valid wake packet; the code's energy event uses the fixed SPMC_ENERGY_CYC count
// - wake packet: six 0xFF bytes then sixteen unbroken copies of node address
`ifndef SPMC_REGS_SVH
`define SPMC_REGS_SVH
`define SPMC_ADDR_W        8
`define SPMC_OFS_MODE      8'h00
`define SPMC_OFS_PORT      8'h04
`define SPMC_OFS_TIMEOUT   8'h08
`define SPMC_OFS_WAKE      8'h0C
`define SPMC_OFS_STATUS    8'h10
`define SPMC_OFS_MAC_LO    8'h14
`define SPMC_OFS_MAC_HI    8'h18
`define SPMC_MODE_LSB      3
`define SPMC_MODE_NORMAL   2'h0
`define SPMC_MODE_ENERGY_DETECT_POWER_DOWN     2'h1
`define SPMC_MODE_SOFTPD   2'h2
`define SPMC_TIMEOUT_RST   32'h00989680
`define SPMC_CLK_NS        40
`define SPMC_ENERGY_NS     100
`define SPMC_ENERGY_CYC    ((`SPMC_ENERGY_NS + `SPMC_CLK_NS - 1) / `SPMC_CLK_NS)
`define SPMC_REFRESH_US    20000
`define SPMC_BURST_US      200
`define SPMC_REFRESH_CYC   (`SPMC_REFRESH_US * 1000 / `SPMC_CLK_NS)
`define SPMC_BURST_CYC     (`SPMC_BURST_US * 1000 / `SPMC_CLK_NS)
`define SPMC_PULSE_CYC     32'h00000019
`define SPMC_RX_STOP_CYC   4'h9
`define SPMC_SYNC_BYTES    3'h6
`define SPMC_ADDR_COPIES   5'h10
`endif

// ---- hw/spmc_pkg.sv ----
// types of the power mode controller
package spmc_pkg;
    typedef enum logic [1:0] {
        SPMC_ST_NORMAL = 2'h0,
        SPMC_ST_SOFTPD = 2'h1,
        SPMC_ST_EDHI   = 2'h2,
        SPMC_ST_EDLO   = 2'h3
    } spmc_state_t;
    typedef struct packed {
        logic [1:0] eee_en;
        logic [2:0] port_pd;
    } spmc_port_cfg_t;
    typedef struct packed {
        logic pme_sel;
        logic pkt_en;
        logic link_en;
        logic energy_en;
    } spmc_wake_cfg_t;
endpackage

// ---- hw/spmc_power_ctrl.sv ----
// global and per-port power mode controller with wake detection
`timescale 1ns/100ps
`default_nettype none
`include "spmc_regs.svh"
module spmc_power_ctrl #(
    parameter int REFRESH_CYC = `SPMC_REFRESH_CYC,
    parameter int BURST_CYC   = `SPMC_BURST_CYC
) (
    input  wire logic                    clk_i,
    input  wire logic                    reset_n_i,
    input  wire logic [`SPMC_ADDR_W-1:0] addr_i,
    input  wire logic [31:0]             wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    output logic      [31:0]             rdata_o,
    input  wire logic [2:0]              straps_i,
    input  wire logic                    energy_i,
    input  wire logic                    autoneg_i,
    input  wire logic [2:0]              link_up_i,
    input  wire logic [1:0]              partner_eee_i,
    input  wire logic [1:0]              mac_tx_lpi_i,
    input  wire logic [1:0]              rx_refresh_i,
    input  wire logic [1:0]              rx_other_i,
    input  wire logic                    rx_valid_i,
    input  wire logic [7:0]              rx_byte_i,
    input  wire logic                    rx_sof_i,
    output logic                         pll_en_o,
    output logic                         mac_en_o,
    output logic                         phy_en_o,
    output logic                         link_pulse_o,
    output logic [2:0]                   port_pd_o,
    output logic [1:0]                   tx_lpi_o,
    output logic [1:0]                   tx_refresh_o,
    output logic [1:0]                   rx_lpi_o,
    output logic [1:0]                   rx_clk_stop_o,
    output logic [2:0]                   strap_cfg_o,
    output logic                         host_interrupt_n_o,
    output logic                         power_event_n_o
);
    spmc_pkg::spmc_state_t    state_ff, nxt_state;
    logic [1:0]               mode_ff;
    spmc_pkg::spmc_port_cfg_t port_ff;
    spmc_pkg::spmc_wake_cfg_t wake_ff;
    logic [31:0]              timeout_ff;
    logic [47:0]              mac_ff;
    logic [2:0]               wake_sts_ff;
    logic [31:0]              idle_cnt_ff;
    logic [3:0]               en_cnt_ff;
    logic [31:0]              pulse_cnt_ff;
    logic                     strap_load_ff;
    logic [2:0]               link_q_ff;
    logic [2:0]               sync_cnt_ff;
    logic [4:0]               copy_cnt_ff;
    logic [2:0]               byte_idx_ff;

    // register decode
    wire sel_mode    = addr_i == `SPMC_OFS_MODE;
    wire sel_port    = addr_i == `SPMC_OFS_PORT;
    wire sel_timeout = addr_i == `SPMC_OFS_TIMEOUT;
    wire sel_wake    = addr_i == `SPMC_OFS_WAKE;
    wire sel_status  = addr_i == `SPMC_OFS_STATUS;
    wire sel_mac_lo  = addr_i == `SPMC_OFS_MAC_LO;
    wire sel_mac_hi  = addr_i == `SPMC_OFS_MAC_HI;
    wire [1:0] wr_mode = wdata_i[`SPMC_MODE_LSB+1:`SPMC_MODE_LSB];
    wire in_softpd   = state_ff == spmc_pkg::SPMC_ST_SOFTPD;
    // leaving soft power-down: a mode write away from it resets all registers
    wire softpd_exit = in_softpd && wr_i && sel_mode && wr_mode != `SPMC_MODE_SOFTPD;
    wire clr_all     = !reset_n_i || softpd_exit;
    wire active      = state_ff == spmc_pkg::SPMC_ST_NORMAL || state_ff == spmc_pkg::SPMC_ST_EDHI;

    // mode register: a write picks the single global mode; one that leaves soft power-down loads normal
    always_ff @(posedge clk_i) begin
        if (clr_all) begin
            mode_ff <= `SPMC_MODE_NORMAL;
        end else if (wr_i && sel_mode) begin
            mode_ff <= wr_mode;
        end
    end

    // configuration registers; only management interface works in soft power-down
    always_ff @(posedge clk_i) begin
        if (clr_all) begin
            port_ff    <= '0;
            wake_ff    <= '0;
            timeout_ff <= `SPMC_TIMEOUT_RST;
            mac_ff     <= '0;
        end else if (wr_i) begin
            if (sel_port) port_ff <= spmc_pkg::spmc_port_cfg_t'(wdata_i[4:0]);
            if (sel_wake) wake_ff <= spmc_pkg::spmc_wake_cfg_t'(wdata_i[3:0]);
            if (sel_timeout) timeout_ff <= wdata_i;
            if (sel_mac_lo) mac_ff[31:0] <= wdata_i;
            if (sel_mac_hi) mac_ff[47:32] <= wdata_i[15:0];
        end
    end

    // straps are taken one cycle after reset or soft power-down exit
    always_ff @(posedge clk_i) begin
        if (clr_all) begin
            strap_load_ff <= 1'b1;
            strap_cfg_o   <= 3'h0;
        end else begin
            strap_load_ff <= 1'b0;
            if (strap_load_ff) strap_cfg_o <= straps_i;
        end
    end

    // energy timers: no-energy idle count and continuous-energy count
    wire energy_ok = en_cnt_ff >= 4'(`SPMC_ENERGY_CYC);
    wire idle_out  = idle_cnt_ff >= timeout_ff;
    always_ff @(posedge clk_i) begin
        if (clr_all || energy_i) idle_cnt_ff <= 32'h0;
        else if (!idle_out) idle_cnt_ff <= idle_cnt_ff + 32'h1;
        if (clr_all || !energy_i) en_cnt_ff <= 4'h0;
        else if (!energy_ok) en_cnt_ff <= en_cnt_ff + 4'h1;
    end

    // global mode sequencer, one state at a time
    always_comb begin
        nxt_state = state_ff;
        unique case (mode_ff)
            `SPMC_MODE_SOFTPD: nxt_state = spmc_pkg::SPMC_ST_SOFTPD;
            `SPMC_MODE_ENERGY_DETECT_POWER_DOWN: begin
                if (state_ff == spmc_pkg::SPMC_ST_EDLO) begin
                    if (energy_ok) nxt_state = spmc_pkg::SPMC_ST_EDHI;
                end else if (idle_out) begin
                    nxt_state = spmc_pkg::SPMC_ST_EDLO;
                end else begin
                    nxt_state = spmc_pkg::SPMC_ST_EDHI;
                end
            end
            default: nxt_state = spmc_pkg::SPMC_ST_NORMAL;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (clr_all) state_ff <= spmc_pkg::SPMC_ST_NORMAL;
        else state_ff <= nxt_state;
    end

    // block enables per global state
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pll_en_o <= 1'b1;
            mac_en_o <= 1'b1;
            phy_en_o <= 1'b1;
            port_pd_o <= 3'h0;
        end else begin
            pll_en_o  <= active;
            mac_en_o  <= active;
            phy_en_o  <= active;
            port_pd_o <= port_ff.port_pd;
        end
    end

    // sparse link pulses in low-power state
    always_ff @(posedge clk_i) begin
        if (clr_all || state_ff != spmc_pkg::SPMC_ST_EDLO) begin
            pulse_cnt_ff <= 32'h0;
            link_pulse_o <= 1'b0;
        end else begin
            pulse_cnt_ff <= (pulse_cnt_ff == 32'(REFRESH_CYC - 1)) ? 32'h0 : pulse_cnt_ff + 32'h1;
            link_pulse_o <= pulse_cnt_ff < `SPMC_PULSE_CYC;
        end
    end

    // EEE paths, only ports 1 and 2
    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_eee
            logic [31:0] ref_cnt_ff;
            logic [3:0]  rx_cnt_ff;
            wire eee_on = port_ff.eee_en[p] && partner_eee_i[p] && active
                          && !port_ff.port_pd[p];
            wire tx_req = eee_on && mac_tx_lpi_i[p];
            always_ff @(posedge clk_i) begin
                if (clr_all || !tx_req) begin
                    ref_cnt_ff        <= 32'h0;
                    tx_lpi_o[p]       <= 1'b0;
                    tx_refresh_o[p]   <= 1'b0;
                end else begin
                    ref_cnt_ff <= (ref_cnt_ff == 32'(REFRESH_CYC - 1)) ? 32'h0 : ref_cnt_ff + 32'h1;
                    tx_lpi_o[p]     <= 1'b1;
                    tx_refresh_o[p] <= ref_cnt_ff < 32'(BURST_CYC);
                end
            end
            always_ff @(posedge clk_i) begin
                if (clr_all || !eee_on || rx_other_i[p]) begin
                    rx_lpi_o[p] <= 1'b0;
                    rx_cnt_ff   <= 4'h0;
                end else begin
                    if (rx_refresh_i[p]) rx_lpi_o[p] <= 1'b1;
                    if (rx_lpi_o[p] && rx_cnt_ff < `SPMC_RX_STOP_CYC) rx_cnt_ff <= rx_cnt_ff + 4'h1;
                end
            end
            assign rx_clk_stop_o[p] = rx_lpi_o[p] && rx_cnt_ff >= `SPMC_RX_STOP_CYC;
        end
    endgenerate

    // wake packet scanner: sync run then sixteen address copies
    wire [7:0] exp_byte = mac_ff[47 - 8*byte_idx_ff -: 8];
    wire sync_done = sync_cnt_ff == `SPMC_SYNC_BYTES;
    wire pkt_hit = rx_valid_i && sync_done && rx_byte_i == exp_byte && byte_idx_ff == 3'h5
                   && copy_cnt_ff == `SPMC_ADDR_COPIES - 5'h1;
    always_ff @(posedge clk_i) begin
        if (clr_all || rx_sof_i) begin
            sync_cnt_ff <= 3'h0;
            copy_cnt_ff <= 5'h0;
            byte_idx_ff <= 3'h0;
        end else if (rx_valid_i) begin
            if (sync_done && rx_byte_i == exp_byte) begin
                byte_idx_ff <= (byte_idx_ff == 3'h5) ? 3'h0 : byte_idx_ff + 3'h1;
                if (byte_idx_ff == 3'h5) copy_cnt_ff <= pkt_hit ? 5'h0 : copy_cnt_ff + 5'h1;
                if (pkt_hit) sync_cnt_ff <= 3'h0;
            end else if (rx_byte_i == 8'hFF) begin
                // extra 0xFF keeps a six-byte sync run alive
                sync_cnt_ff <= sync_done ? sync_cnt_ff : sync_cnt_ff + 3'h1;
                copy_cnt_ff <= 5'h0;
                byte_idx_ff <= 3'h0;
            end else begin
                sync_cnt_ff <= 3'h0;
                copy_cnt_ff <= 5'h0;
                byte_idx_ff <= 3'h0;
            end
        end
    end

    // wake events, sticky; a new event wins over a clear
    wire link_rise = |(link_up_i & ~link_q_ff);
    wire [2:0] wake_evt = {wake_ff.pkt_en && pkt_hit, wake_ff.link_en && link_rise,
                           wake_ff.energy_en && energy_i && idle_out == 1'b0 && idle_cnt_ff == 32'h0
                           && state_ff == spmc_pkg::SPMC_ST_EDLO && energy_ok};
    wire [2:0] wake_clr = (wr_i && sel_status) ? wdata_i[2:0] : 3'h0;
    always_ff @(posedge clk_i) begin
        if (clr_all) begin
            wake_sts_ff <= 3'h0;
            link_q_ff   <= 3'h0;
        end else begin
            wake_sts_ff <= (wake_sts_ff & ~wake_clr) | wake_evt;
            link_q_ff   <= link_up_i;
        end
    end
    assign host_interrupt_n_o = !(|wake_sts_ff && !wake_ff.pme_sel);
    assign power_event_n_o    = !(|wake_sts_ff && wake_ff.pme_sel);

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || !rd_i) rdata_o <= 32'h0;
        else rdata_o <= sel_mode    ? {27'h0, mode_ff, 3'h0}
                      : sel_port    ? {27'h0, port_ff}
                      : sel_timeout ? timeout_ff
                      : sel_wake    ? {28'h0, wake_ff}
                      : sel_status  ? {26'h0, autoneg_i, state_ff, wake_sts_ff}
                      : sel_mac_lo  ? mac_ff[31:0]
                      : sel_mac_hi  ? {16'h0, mac_ff[47:32]}
                      : 32'h0;
    end

    // assertions
    a_softpd_disables: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        in_softpd |=> !pll_en_o && !mac_en_o) else $error("blocks on in soft power-down");
    a_edlo_wake_up: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        state_ff == spmc_pkg::SPMC_ST_EDLO && energy_ok && mode_ff == `SPMC_MODE_ENERGY_DETECT_POWER_DOWN
        |=> state_ff == spmc_pkg::SPMC_ST_EDHI) else $error("no return to normal-power");
    a_idle_to_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        state_ff == spmc_pkg::SPMC_ST_EDHI && idle_out && mode_ff == `SPMC_MODE_ENERGY_DETECT_POWER_DOWN
        |=> state_ff == spmc_pkg::SPMC_ST_EDLO) else $error("no entry to low-power");
    a_lpi_negotiated: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        tx_lpi_o[0] |-> $past(partner_eee_i[0]) && $past(port_ff.eee_en[0])) else $error("lpi without negotiation");
    a_rx_stop_late: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(rx_clk_stop_o[0]) |-> $past(rx_lpi_o[0], 9)) else $error("rx clock stopped early");
    a_notify_select: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !(host_interrupt_n_o == 1'b0 && power_event_n_o == 1'b0)) else $error("both notify pins");
    a_soft_exit_reset: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        softpd_exit |=> port_ff == '0 && state_ff == spmc_pkg::SPMC_ST_NORMAL) else $error("no reset on exit");
    a_mode_normal: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        mode_ff == 2'h3 |=> state_ff == spmc_pkg::SPMC_ST_NORMAL) else $error("code 11 not normal");
endmodule
`default_nettype wire

// ---- tb/spmc_host_model.sv ----
// host processor model driving the register port of the power mode controller
`timescale 1ns/100ps
`default_nettype none
`include "spmc_regs.svh"
module spmc_host_model (
    input  wire logic                    clk_i,
    input  wire logic [31:0]             rdata_i,
    output logic      [`SPMC_ADDR_W-1:0] addr_o,
    output logic      [31:0]             wdata_o,
    output logic                         wr_o,
    output logic                         rd_o
);
    // idle bus at time zero
    initial begin
        addr_o = 8'h00;
        wdata_o = 32'h0;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // one write cycle; mode writes from normal select the other modes
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;  // released lines do not keep the last value
        wdata_o <= ~d;
    endtask
    // one read cycle; data taken in the cycle after the strobe
    task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench of the power mode controller
`timescale 1ns/100ps
`default_nettype none
`include "spmc_regs.svh"
module testbench;
    localparam int RCYC = 100;
    localparam int BCYC = 10;
    localparam logic [31:0] M_EN = 32'hE0000, M_PLS = 32'h10000, M_PD = 32'h0E000, M_TXL = 32'h01800;
    localparam logic [31:0] M_TXR = 32'h00600, M_RXL = 32'h00180, M_RXS = 32'h00060, M_NTF = 32'h00003;
    logic        clk_i = 1'b0;
    logic        reset_n_i, wr_i, rd_i, energy_i, autoneg_i, rx_valid_i, rx_sof_i;
    logic        pll_en_o, mac_en_o, phy_en_o, link_pulse_o, host_interrupt_n_o, power_event_n_o;
    logic [7:0]  addr_i, rx_byte_i;
    logic [31:0] wdata_i, rdata_o, rv, obs;
    logic [31:0] lf = 32'h084F;
    logic [2:0]  straps_i, link_up_i, port_pd_o, strap_cfg_o;
    logic [1:0]  partner_eee_i, mac_tx_lpi_i, rx_refresh_i, rx_other_i;
    logic [1:0]  tx_lpi_o, tx_refresh_o, rx_lpi_o, rx_clk_stop_o;
    logic [47:0] mac;
    int          n_errors = 0;
    int          checks_done = 0;
    int          k, cnt;
    spmc_power_ctrl #(.REFRESH_CYC(RCYC), .BURST_CYC(BCYC)) u_dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .straps_i(straps_i), .energy_i(energy_i), .autoneg_i(autoneg_i),
        .link_up_i(link_up_i), .partner_eee_i(partner_eee_i), .mac_tx_lpi_i(mac_tx_lpi_i),
        .rx_refresh_i(rx_refresh_i), .rx_other_i(rx_other_i), .rx_valid_i(rx_valid_i),
        .rx_byte_i(rx_byte_i), .rx_sof_i(rx_sof_i), .pll_en_o(pll_en_o), .mac_en_o(mac_en_o),
        .phy_en_o(phy_en_o), .link_pulse_o(link_pulse_o), .port_pd_o(port_pd_o), .tx_lpi_o(tx_lpi_o),
        .tx_refresh_o(tx_refresh_o), .rx_lpi_o(rx_lpi_o), .rx_clk_stop_o(rx_clk_stop_o),
        .strap_cfg_o(strap_cfg_o), .host_interrupt_n_o(host_interrupt_n_o), .power_event_n_o(power_event_n_o));
    spmc_host_model u_host (.clk_i(clk_i), .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i),
        .wr_o(wr_i), .rd_o(rd_i));
    // all outputs except rdata_o in one word, masks pick fields
    assign obs = {12'h000, pll_en_o, mac_en_o, phy_en_o, link_pulse_o, port_pd_o, tx_lpi_o, tx_refresh_o,
                  rx_lpi_o, rx_clk_stop_o, strap_cfg_o, host_interrupt_n_o, power_event_n_o};
    always #20 clk_i = ~clk_i;
    // expectation helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] st_exp(input logic [1:0] st, input logic [2:0] wk);
        return {26'h0, autoneg_i, st, wk};
    endfunction
    // compare, bus and wait helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        u_host.write_reg(a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        u_host.read_reg(a, rv);
        chk(rv, e);
    endtask
    task automatic wait_state(input logic [1:0] s, input int lim);
        for (k = 0; k < lim; k++) begin
            u_host.read_reg(`SPMC_OFS_STATUS, rv);
            if (rv[4:3] === s) break;
        end
        chk({30'h0, rv[4:3]}, {30'h0, s});
        if (rv[4:3] !== s) report_and_stop();
    endtask
    task automatic wait_obs(input logic [31:0] m, input logic [31:0] w, input int lim);
        for (k = 0; k < lim && (obs & m) !== w; k++) @(posedge clk_i);
        chk(obs & m, w);
        if ((obs & m) !== w) report_and_stop();
    endtask
    // settle one period, then count high cycles over the next
    task automatic count_hi(input logic [31:0] m, input logic [31:0] e);
        cnt = 0;
        repeat (2 * RCYC) begin
            @(posedge clk_i);
            if (k++ >= RCYC && (obs & m) !== 32'h0) cnt++;
        end
        chk(32'(cnt), e);
    endtask
    task automatic send_frame(input logic [47:0] m, input int copies);
        @(posedge clk_i);
        rx_sof_i <= 1'b1;
        @(posedge clk_i);
        rx_sof_i <= 1'b0;
        for (int i = 0; i < 7 + copies * 6; i++) begin
            rx_valid_i <= 1'b1;
            rx_byte_i <= (i == 0) ? 8'h55 : (i < 7) ? 8'hFF : m[8 * (5 - (i - 7) % 6) +: 8];
            @(posedge clk_i);
        end
        rx_byte_i <= 8'h00;  // breaks the run after the last copy
        @(posedge clk_i);
        rx_valid_i <= 1'b0;
        rx_byte_i <= 8'hFF;
    endtask
    task automatic report_and_stop();
        $display("errors=%0d checks=%0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        {reset_n_i, energy_i, straps_i, link_up_i, rx_valid_i, rx_sof_i, rx_byte_i} = {2'b01, 3'h5, 13'h0};
        {partner_eee_i, mac_tx_lpi_i, rx_refresh_i, rx_other_i} = 8'h00;
        autoneg_i = 1'b1;
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rchk(`SPMC_OFS_MODE, 32'h0);
        rchk(`SPMC_OFS_PORT, 32'h0);
        rchk(`SPMC_OFS_TIMEOUT, `SPMC_TIMEOUT_RST);
        rchk(`SPMC_OFS_STATUS, st_exp(2'h0, 3'h0));
        rchk(8'h20, 32'h0);
        wait_obs(M_EN | 32'h1C, M_EN | 32'h14, 4);
        // random port settings leave the global mode alone
        for (int r = 0; r < 3; r++) begin
            lf = lfsr_next(lf);
            wreg(`SPMC_OFS_PORT, {27'h0, lf[4:0]});
            wreg(`SPMC_OFS_TIMEOUT, lf);
            rchk(`SPMC_OFS_PORT, {27'h0, lf[4:0]});
            rchk(`SPMC_OFS_TIMEOUT, lf);
            wait_obs(M_PD, {16'h0, lf[2:0], 13'h0}, 4);
            rchk(`SPMC_OFS_STATUS, st_exp(2'h0, 3'h0));
        end
        // soft power-down keeps register access, leaving it restores defaults
        wreg(`SPMC_OFS_MODE, 32'h10);
        wait_state(2'h1, 20);
        wait_obs(M_EN, 32'h0, 4);
        lf = lfsr_next(lf);
        straps_i <= lf[2:0];
        wreg(`SPMC_OFS_TIMEOUT, lf);
        rchk(`SPMC_OFS_TIMEOUT, lf);
        wreg(`SPMC_OFS_MODE, 32'h0);
        wait_state(2'h0, 20);
        rchk(`SPMC_OFS_TIMEOUT, `SPMC_TIMEOUT_RST);
        rchk(`SPMC_OFS_PORT, 32'h0);
        wait_obs(M_EN | M_PD | 32'h1C, M_EN | {27'h0, lf[2:0], 2'h0}, 4);
        wreg(`SPMC_OFS_MODE, 32'h18);
        rchk(`SPMC_OFS_STATUS, st_exp(2'h0, 3'h0));
        // energy detect: quiet cable drops to low power, steady energy wakes it
        wreg(`SPMC_OFS_TIMEOUT, 32'h14);
        wreg(`SPMC_OFS_WAKE, 32'h9);
        wreg(`SPMC_OFS_MODE, 32'h08);
        rchk(`SPMC_OFS_MODE, 32'h08);
        wait_state(2'h2, 20);
        chk(obs & M_EN, M_EN);
        energy_i <= 1'b0;
        wait_state(2'h3, 40);
        wait_obs(M_EN, 32'h0, 4);
        k = 0;
        count_hi(M_PLS, `SPMC_PULSE_CYC);
        energy_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        energy_i <= 1'b0;
        rchk(`SPMC_OFS_STATUS, st_exp(2'h3, 3'h0));
        energy_i <= 1'b1;
        wait_state(2'h2, 10);
        wait_obs(M_NTF, 32'h2, 4);
        rchk(`SPMC_OFS_STATUS, st_exp(2'h2, 3'h1));
        wreg(`SPMC_OFS_STATUS, 32'h1);
        wait_obs(M_NTF, 32'h3, 4);
        wreg(`SPMC_OFS_MODE, 32'h0);
        // link-up and wake packet events on the interrupt pin
        wreg(`SPMC_OFS_WAKE, 32'h2);
        link_up_i <= 3'h4;
        wait_obs(M_NTF, 32'h1, 6);
        rchk(`SPMC_OFS_STATUS, st_exp(2'h0, 3'h2));
        wreg(`SPMC_OFS_STATUS, 32'h2);
        lf = lfsr_next(lf);
        mac = {lf[15:0], lf};
        wreg(`SPMC_OFS_MAC_LO, mac[31:0]);
        wreg(`SPMC_OFS_MAC_HI, {16'h0, mac[47:32]});
        wreg(`SPMC_OFS_WAKE, 32'h4);
        send_frame(mac, 15);
        repeat (4) @(posedge clk_i);
        chk(obs & M_NTF, 32'h3);
        send_frame(mac, 16);
        wait_obs(M_NTF, 32'h1, 6);
        rchk(`SPMC_OFS_STATUS, st_exp(2'h0, 3'h4));
        // low-power idle per port and per direction
        partner_eee_i <= 2'h3;
        mac_tx_lpi_i <= 2'h3;
        wreg(`SPMC_OFS_PORT, 32'h08);
        wait_obs(M_TXL, 32'h00800, 4);
        k = 0;
        count_hi(M_TXR, 32'(BCYC));
        wreg(`SPMC_OFS_PORT, 32'h18);
        partner_eee_i <= 2'h1;
        wait_obs(M_TXL, 32'h00800, 4);
        partner_eee_i <= 2'h3;
        mac_tx_lpi_i <= 2'h2;
        wait_obs(M_TXL, 32'h01000, 4);
        rx_refresh_i <= 2'h1;
        @(posedge clk_i);
        rx_refresh_i <= 2'h0;
        wait_obs(M_RXL, 32'h00080, 4);
        repeat (6) @(posedge clk_i);
        chk(obs & M_RXS, 32'h0);
        wait_obs(M_RXS, 32'h00020, 6);
        rx_other_i <= 2'h1;
        @(posedge clk_i);
        rx_other_i <= 2'h0;
        wait_obs(M_RXL | M_RXS | M_TXL, 32'h01000, 4);
        report_and_stop();
    end
    // cuts a hang short
    initial begin
        #1000000;
        n_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
